// >>> lfxo_defines.vh
// register offsets, field positions, reset values and timing counts for the oscillator control
`ifndef LFXO_DEFINES_VH
`define LFXO_DEFINES_VH
`define LFXO_LF_CTRL_ADDR     8'h86
`define LFXO_EXT_CTRL_ADDR    8'hB1
`define LFXO_LF_EN_BIT        7
`define LFXO_LF_RDY_BIT       6
`define LFXO_TRIM_HI          5
`define LFXO_TRIM_LO          2
`define LFXO_DIV_HI           1
`define LFXO_DIV_LO           0
`define LFXO_XVLD_BIT         7
`define LFXO_XMODE_HI         6
`define LFXO_XMODE_LO         4
`define LFXO_XRANGE_HI        2
`define LFXO_XRANGE_LO        0
`define LFXO_XRANGE_RST       3'h0
`define LFXO_XMODE_UNUSED     3'h1
`define LFXO_TRIM_RST         4'h8
`define LFXO_DIV_RST          2'h0
`define LFXO_XMODE_OFF        3'h0
`define LFXO_XMODE_CMOS       3'h2
`define LFXO_XMODE_CMOS_DIV2  3'h3
`define LFXO_XMODE_RC         3'h4
`define LFXO_XMODE_CAP        3'h5
`define LFXO_XMODE_XTAL       3'h6
`define LFXO_XMODE_XTAL_DIV2  3'h7
`define LFXO_LF_SETTLE_EDGES  8'h10
`define LFXO_X_SETTLE_EDGES   16'h0400
`endif

// >>> lfxo_sync3.v
// three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/100ps
`default_nettype none
module lfxo_sync3
(
    input  wire clk,        // system clock
    input  wire sys_rst,    // synchronous reset, active high
    input  wire async_in,   // level from outside the clock domain
    output reg  sync_out    // filtered level
);
    reg s1; // first stage, read only by s2
    reg s2; // second stage
    reg s3; // third stage

    // shift chain; output follows only when stages two and three agree
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            s1       <= 1'b0;
            s2       <= 1'b0;
            s3       <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                sync_out <= s3;
        end
    end
endmodule // lfxo_sync3
`default_nettype wire

// >>> lfxo_osc_ctrl.v
// low-frequency oscillator and external oscillator control logic
// Overview of operation
// (RULE1) lf oscillator runs only while enable set
// (RULE2) ready flag sets once lf output stable
// (RULE3) ready clears only on reset or divider change
// (RULE4) four-bit trim: zero fastest, all ones slowest
// (RULE5) divider select 00/01/10/11 gives 8/4/2/1
// (RULE6) crystal modes claim both pins, others one; the code claims none in the off and unused codes
// (RULE7) software skips claimed pins in routing matrix
// (RULE8) software sets oscillator pins analog or digital
// (RULE9) external clock offered to system and peripherals
// (RULE10) crystal divide mode halves with even duty
// (RULE11) valid detector readable after crystal enable
// (RULE12) software waits, polls valid, then switches clock
// (RULE13) software picks crystal mode and frequency range
// (RULE14) valid reads one only when running stable
// (RULE15) lf output is trimmed clock through divider
// two control registers share one strobe bus; reads come back registered
// one cycle after the strobe and stand until the next read
`timescale 1ns/100ps
`default_nettype none
`include "lfxo_defines.vh"
module lfxo_osc_ctrl
(
    input  wire       clk,            // system clock, 100 MHz
    input  wire       sys_rst,        // synchronous reset, active high
    input  wire [7:0] sfr_addr,       // register address
    input  wire [7:0] sfr_wdata,      // write data
    input  wire       sfr_wr,         // write strobe, one cycle
    input  wire       sfr_rd,         // read strobe, one cycle
    output reg  [7:0] sfr_rdata,      // read data, registered
    input  wire       lf_osc_raw,     // analog lf oscillator output
    output reg        lf_osc_run,     // enables the lf oscillator core
    output reg  [3:0] lf_trim_out,    // trim code to the oscillator core
    output reg        lf_clk_en,      // divided lf rate as one-cycle pulse
    input  wire       ext_osc_raw,    // external oscillator, from pin or amplifier
    output reg        xtal_in_claim,  // crystal_in_pin taken by oscillator
    output reg        xtal_out_claim, // crystal_out_pin taken by oscillator
    output reg  [2:0] ext_freq_out,   // drive range to the amplifier
    output reg        ext_clk_en,     // external rate as one-cycle pulse
    output reg        ext_clk_valid   // external clock valid, mirrors flag
);
    reg        lf_osc_enable;       // lf enable bit
    reg        lf_osc_ready;        // lf ready flag
    reg  [3:0] lf_fine_trim;        // trim field
    reg  [1:0] lf_divider_select;   // divider field
    reg  [2:0] ext_mode;            // external mode field
    reg  [2:0] ext_freq_range;      // external range field
    reg        ext_valid_bit;       // external valid flag
    wire       lf_sync;             // synchronised lf level
    wire       ext_sync;            // synchronised external level
    reg        lf_prev;             // last lf level, edge detection
    reg        ext_prev;            // last external level
    reg  [2:0] lf_div_cnt;          // lf rising edge counter
    reg  [7:0] lf_settle;           // lf edges seen while enabled, since the last divider change
    reg [15:0] x_settle;            // external edges seen in running non-cmos modes since the last external register write
    reg        ext_half;            // divide-by-two toggle
    wire       lf_rise;             // lf rising edge
    wire       ext_rise;            // external rising edge
    wire       ext_on;              // external circuit on
    wire       ext_xtal;            // crystal modes
    wire       ext_div2;            // any divide-by-two mode
    wire       ext_cmos;            // cmos clock modes
    wire       lf_wr;               // write to lf register
    wire       ext_wr;              // write to external register
    wire       div_change;          // write alters divider field
    reg        lf_tick;             // selected divided lf edge

    // pin inputs pass three stages before use
    lfxo_sync3 u_lf_sync (.clk(clk), .sys_rst(sys_rst), .async_in(lf_osc_raw), .sync_out(lf_sync));
    lfxo_sync3 u_x_sync (.clk(clk), .sys_rst(sys_rst), .async_in(ext_osc_raw), .sync_out(ext_sync));

    // one-cycle rising edge strobes from the filtered levels
    assign lf_rise    = lf_sync & ~lf_prev;
    assign ext_rise   = ext_sync & ~ext_prev;
    // address decode of the two control registers
    assign lf_wr      = sfr_wr && (sfr_addr == `LFXO_LF_CTRL_ADDR);
    assign ext_wr     = sfr_wr && (sfr_addr == `LFXO_EXT_CTRL_ADDR);
    // a write that alters the divider restarts the settle count
    assign div_change = lf_wr &&
        (sfr_wdata[`LFXO_DIV_HI:`LFXO_DIV_LO] != lf_divider_select);
    // mode decode; the unused code behaves as off
    assign ext_on     = (ext_mode != `LFXO_XMODE_OFF) && (ext_mode != `LFXO_XMODE_UNUSED);
    assign ext_xtal   = (ext_mode == `LFXO_XMODE_XTAL) || (ext_mode == `LFXO_XMODE_XTAL_DIV2);
    assign ext_div2   = (ext_mode == `LFXO_XMODE_XTAL_DIV2) ||
                        (ext_mode == `LFXO_XMODE_CMOS_DIV2);
    assign ext_cmos   = (ext_mode == `LFXO_XMODE_CMOS) || (ext_mode == `LFXO_XMODE_CMOS_DIV2);

    // pick divided lf edge: counter bit toggles at the chosen ratio
    always @*
    begin
        case (lf_divider_select) // RULE5
            2'h0:    lf_tick = lf_rise && (lf_div_cnt == 3'h7);
            2'h1:    lf_tick = lf_rise && (lf_div_cnt[1:0] == 2'h3);
            2'h2:    lf_tick = lf_rise && lf_div_cnt[0];
            2'h3:    lf_tick = lf_rise;
            default: lf_tick = 1'b0;
        endcase
    end

    // register writes and lf state
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            // all state idle; trim back to its reset code
            lf_osc_enable     <= 1'b0;
            lf_osc_ready      <= 1'b0;
            lf_fine_trim      <= `LFXO_TRIM_RST;
            lf_divider_select <= `LFXO_DIV_RST;
            ext_mode          <= `LFXO_XMODE_OFF;
            ext_freq_range    <= `LFXO_XRANGE_RST;
            lf_prev           <= 1'b0;
            lf_div_cnt        <= 3'h0;
            lf_settle         <= 8'h00;
            lf_clk_en         <= 1'b0;
            lf_osc_run        <= 1'b0;
            lf_trim_out       <= `LFXO_TRIM_RST;
        end
        else
        begin
            // edge history for the lf strobe
            lf_prev <= lf_sync;
            // writable lf fields; the ready bit ignores writes
            if (lf_wr)
            begin
                lf_osc_enable     <= sfr_wdata[`LFXO_LF_EN_BIT];
                lf_fine_trim      <= sfr_wdata[`LFXO_TRIM_HI:`LFXO_TRIM_LO];
                lf_divider_select <= sfr_wdata[`LFXO_DIV_HI:`LFXO_DIV_LO];
            end
            // writable external fields; valid bit and bit 3 ignore writes
            if (ext_wr)
            begin
                ext_mode       <= sfr_wdata[`LFXO_XMODE_HI:`LFXO_XMODE_LO];
                ext_freq_range <= sfr_wdata[`LFXO_XRANGE_HI:`LFXO_XRANGE_LO];
            end
            // core controls follow the fields one cycle later
            lf_osc_run  <= lf_osc_enable; // RULE1
            lf_trim_out <= lf_fine_trim; // RULE4
            // divider restarts on a change so first output is a full period
            if (div_change || !lf_osc_enable)
                lf_div_cnt <= 3'h0;
            else if (lf_rise)
                lf_div_cnt <= lf_div_cnt + 3'h1;
            // pulse only while enabled, never on the divider-change cycle
            lf_clk_en <= lf_osc_enable && lf_tick && !div_change; // RULE15
            // settle count; ready sets after enough edges while enabled
            if (div_change)
                lf_settle <= 8'h00;
            else if (lf_osc_enable && lf_rise && lf_settle != `LFXO_LF_SETTLE_EDGES)
                lf_settle <= lf_settle + 8'h01;
            // the divider-change clear beats a same-cycle set
            if (div_change)
                lf_osc_ready <= 1'b0; // RULE3
            else if (lf_settle == `LFXO_LF_SETTLE_EDGES)
                lf_osc_ready <= 1'b1; // RULE2
        end
    end

    // external oscillator: valid detector, halving stage, pin claims
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            // external side idle, no pin claimed
            ext_prev       <= 1'b0;
            x_settle       <= 16'h0000;
            ext_valid_bit  <= 1'b0;
            ext_half       <= 1'b0;
            ext_clk_en     <= 1'b0;
            xtal_in_claim  <= 1'b0;
            xtal_out_claim <= 1'b0;
            ext_freq_out   <= `LFXO_XRANGE_RST;
            ext_clk_valid  <= 1'b0;
        end
        else
        begin
            // edge history for the external strobe
            ext_prev <= ext_sync;
            // valid detector counts edges; cmos modes always read zero
            if (!ext_on || ext_cmos || ext_wr)
                x_settle <= 16'h0000;
            else if (ext_rise && x_settle != `LFXO_X_SETTLE_EDGES)
                x_settle <= x_settle + 16'h0001;
            ext_valid_bit <= ext_on && !ext_cmos && !ext_wr &&
                             (x_settle == `LFXO_X_SETTLE_EDGES); // RULE11 RULE14
            // port copy of the flag, one cycle behind the register
            ext_clk_valid <= ext_valid_bit;
            // halving stage gives one pulse per two edges, even duty
            if (!ext_div2)
                ext_half <= 1'b0;
            else if (ext_rise)
                ext_half <= ~ext_half; // RULE10
            // pulse per rise, or per second rise in the halving modes
            ext_clk_en <= ext_on && ext_rise && (!ext_div2 || ext_half); // RULE9
            // crystal modes claim both pins, the other running modes the output pin only, off and unused none
            xtal_in_claim  <= ext_xtal; // RULE6
            xtal_out_claim <= ext_on; // RULE6
            // range code goes straight to the amplifier drive
            ext_freq_out   <= ext_freq_range;
        end
    end

    // read path; unmapped addresses read zero
    always @(posedge clk)
    begin
        if (sys_rst)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
        begin
            // lf word: enable, ready, trim, divider
            // external word: valid, mode, a zero, range
            case (sfr_addr)
                `LFXO_LF_CTRL_ADDR:  sfr_rdata <= {lf_osc_enable, lf_osc_ready,
                                                   lf_fine_trim, lf_divider_select};
                `LFXO_EXT_CTRL_ADDR: sfr_rdata <= {ext_valid_bit, ext_mode, 1'b0,
                                                   ext_freq_range};
                default:             sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule // lfxo_osc_ctrl
`default_nettype wire

// >>> lfxo_osc_checker.sv
// assertion checker for the oscillator control ports
`timescale 1ns/100ps
`default_nettype none
module lfxo_osc_checker
(
    input wire       clk,
    input wire       sys_rst,
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire       sfr_wr,
    input wire       sfr_rd,
    input wire [7:0] sfr_rdata,
    input wire       lf_osc_run,
    input wire [3:0] lf_trim_out,
    input wire       lf_clk_en,
    input wire       xtal_in_claim,
    input wire       xtal_out_claim,
    input wire       ext_clk_valid
);
    wire        lw = sfr_wr && sfr_addr == 8'h86; // lf register write
    wire        xw = sfr_wr && sfr_addr == 8'hB1; // ext register write
    reg  [11:0] age;                              // cycles since ext write, saturating
    // age restarts on every ext write, since that restarts the valid count
    always @(posedge clk)
        age <= (sys_rst || xw) ? 12'h000 : age + {11'h000, age != 12'hFFF};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_run_follows_en: assert property (lw |-> ##2 lf_osc_run == $past(sfr_wdata[7], 2))
        else $error("lf run does not follow enable");
    a_lf_quiet_off: assert property (!lf_osc_run [*8] |-> !lf_clk_en)
        else $error("lf pulse while disabled");
    a_trim_follows: assert property (lw |-> ##2 lf_trim_out == $past(sfr_wdata[5:2], 2))
        else $error("trim output wrong");
    a_in_claim_mode: assert property (xw ##1 !xw [*2] |=>
        xtal_in_claim == ($past(sfr_wdata[6], 3) && $past(sfr_wdata[5], 3)))
        else $error("input pin claim wrong");
    a_out_claim_mode: assert property (xw ##1 !xw [*2] |=>
        xtal_out_claim == ($past(sfr_wdata[6:4], 3) >= 3'h2))
        else $error("output pin claim wrong");
    a_valid_not_early: assert property (ext_clk_valid && age > 12'h004 |-> age > 12'h7D0)
        else $error("external valid too early");
    a_rdata_holds: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
        else $error("read data changed without read");
    a_unmapped_zero: assert property (sfr_rd && sfr_addr != 8'h86 && sfr_addr != 8'hB1
        |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // lfxo_osc_checker
bind lfxo_osc_ctrl lfxo_osc_checker u_chk (.clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .sfr_rdata, .lf_osc_run, .lf_trim_out, .lf_clk_en, .xtal_in_claim,
    .xtal_out_claim, .ext_clk_valid);
`default_nettype wire

// >>> lf_and_external_osc_control_tb_top.sv
// self-checking bench for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
module lf_and_external_osc_control_tb_top;
    reg        clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg  [7:0] sfr_addr = 8'h00;
    reg  [7:0] sfr_wdata = 8'h00;
    reg        sfr_wr = 1'b0;
    reg        sfr_rd = 1'b0;
    reg        lf_osc_raw = 1'b0;  // lf oscillator, period 6 cycles
    reg        ext_osc_raw = 1'b0; // external oscillator, period 4 cycles
    wire [7:0] sfr_rdata;
    wire       lf_osc_run;
    wire [3:0] lf_trim_out;
    wire       lf_clk_en;
    wire       xtal_in_claim;
    wire       xtal_out_claim;
    wire [2:0] ext_freq_out;
    wire       ext_clk_en;
    wire       ext_clk_valid;
    integer    err_count = 0;
    integer    compares = 0;
    integer    cyc = 0;
    integer    i;
    integer    n;
    reg  [7:0] rv;                 // last read value
    always #5 clk = ~clk;
    lfxo_osc_ctrl DUT (.clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
        .lf_osc_raw, .lf_osc_run, .lf_trim_out, .lf_clk_en, .ext_osc_raw, .xtal_in_claim,
        .xtal_out_claim, .ext_freq_out, .ext_clk_en, .ext_clk_valid);
    // oscillator sources and hang guard, all off the falling edge
    always @(negedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc % 3 == 2)
            lf_osc_raw <= ~lf_osc_raw;
        if (cyc % 2 == 1)
            ext_osc_raw <= ~ext_osc_raw;
        if (cyc == 20000)
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t: timeout", $time);
            test_done;
        end
    end
    task chk(input [7:0] seen, input [7:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    end
    endtask
    // one write cycle, then an idle edge
    task wr(input [7:0] a, input [7:0] d);
    begin
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk) sfr_wr = 1'b0;
        @(negedge clk);
    end
    endtask
    // one read cycle, data taken after the answering edge
    task rd(input [7:0] a);
    begin
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk) sfr_rd = 1'b0;
        @(negedge clk) rv = sfr_rdata;
    end
    endtask
    // cycles between pulses minus one, lf (s=0) or external (s=1)
    task gap(input s);
    integer k;
    begin
        for (k = 0; k < 3; k = k + 1)
        begin
            n = 0;
            @(negedge clk);
            while ((s ? ext_clk_en : lf_clk_en) !== 1'b1 && n < 200)
            begin
                n = n + 1;
                @(negedge clk);
            end
        end
    end
    endtask
    task t_reset;
    begin
        rd(8'h86);
        chk(rv, 8'h20);
        rd(8'hB1);
        chk(rv, 8'h00);
        rd(8'h55);
        chk(rv, 8'h00);
        wr(8'h86, 8'h03);
        n = 0;
        repeat (60) @(negedge clk) n = n + lf_clk_en;
        chk(n, 0);
        chk(lf_osc_run, 1'b0);
    end
    endtask
    task t_lf_ready;
    begin
        wr(8'h86, 8'hC3);
        rd(8'h86);
        chk(rv, 8'h83);
        repeat (150) @(negedge clk);
        rd(8'h86);
        chk(rv, 8'hC3);
        wr(8'h86, 8'hBF);
        rd(8'h86);
        chk(rv, 8'hFF);
        chk(lf_trim_out, 4'hF);
        wr(8'h86, 8'h03);
        rd(8'h86);
        chk(rv, 8'h43);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        rd(8'h86);
        chk(rv, 8'h20);
        wr(8'h86, 8'h82);
        rd(8'h86);
        chk(rv, 8'h82);
    end
    endtask
    task t_lf_div;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h86, 8'h80 | i);
            gap(1'b0);
            chk(n, 6 * (8 >> i) - 1);
            chk(lf_trim_out, 4'h0);
        end
    end
    endtask
    task t_ext_modes;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(8'hB1, i * 17);
            @(negedge clk);
            chk(xtal_in_claim, i >= 6);
            chk(xtal_out_claim, i >= 2);
            chk(ext_freq_out, i);
            rd(8'hB1);
            chk(rv, i * 17);
        end
    end
    endtask
    task t_ext_valid;
    begin
        wr(8'hB1, 8'hEA);
        repeat (1000) @(negedge clk);
        rd(8'hB1);
        chk(rv, 8'h62);
        repeat (3400) @(negedge clk);
        rd(8'hB1);
        chk(rv, 8'hE2);
        chk(ext_clk_valid, 1'b1);
        gap(1'b1);
        chk(n, 3);
        wr(8'hB1, 8'h72);
        gap(1'b1);
        chk(n, 7);
        wr(8'hB1, 8'h22);
        repeat (4500) @(negedge clk);
        rd(8'hB1);
        chk(rv, 8'h22);
        chk(ext_clk_valid, 1'b0);
    end
    endtask
    task test_done;
    begin
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    // reset for 12 cycles, then the scenarios in turn
    initial
    begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        t_reset;
        t_lf_ready;
        t_lf_div;
        t_ext_modes;
        t_ext_valid;
        test_done;
    end
endmodule // lf_and_external_osc_control_tb_top
`default_nettype wire
